// ==== rtl/fbt_map.vh ====
// Command codes, output modes and geometry for the bank output tracker
`ifndef FBT_MAP_VH
`define FBT_MAP_VH
`define FBT_NBANK 16
`define FBT_BANK_W 4
`define FBT_BLK_W 8
`define FBT_DATA_W 16
`define FBT_MODE_W 2
`define FBT_MODE_ARRAY 2'h0
`define FBT_MODE_STATUS 2'h1
`define FBT_MODE_SIG 2'h2
`define FBT_MODE_QUERY 2'h3
`define FBT_MODE_RESET 2'h0
`define FBT_CMD_READ_ARRAY 8'hFF
`define FBT_CMD_READ_STATUS 8'h70
`define FBT_CMD_CLEAR_STATUS 8'h50
`define FBT_CMD_READ_SIG 8'h90
`define FBT_CMD_READ_QUERY 8'h98
`define FBT_CMD_PROGRAM 8'h40
`define FBT_CMD_PROGRAM_ALT 8'h10
`define FBT_CMD_ERASE 8'h20
`define FBT_CMD_BUF_PROG 8'hE8
`define FBT_CMD_FACTORY 8'h80
`define FBT_CMD_CONFIRM 8'hD0
`define FBT_CMD_SUSPEND 8'hB0
`define FBT_CMD_LOCK_SETUP 8'h60
`define FBT_CMD_OTP_SETUP 8'hC0
`define FBT_CMD_BLANK_SETUP 8'hBC
`define FBT_CMD_BLANK_CONFIRM 8'hCB
`define FBT_CMD_LOCK_CONFIRM 8'h01
`define FBT_CMD_LOCKDOWN_CONFIRM 8'h2F
`define FBT_CMD_SETCFG_CONFIRM 8'h03
`define FBT_FACTORY_EXIT 16'hFFFF
`endif

// ==== rtl/fbt_cmd_decode.v ====
// Command code classifier
`timescale 1ns/1ps
`include "fbt_map.vh"
module fbt_cmd_decode (
  input wire [7:0] code,
  input wire pec_busy,
  output reg [2:0] mode_sel,
  output reg legal,
  output reg setup_ignored,
  output reg is_factory
);
  always @*
  begin
    mode_sel = 3'h0;
    legal = 1'b1;
    setup_ignored = 1'b0;
    is_factory = 1'b0;
    case (code)
      `FBT_CMD_READ_ARRAY: mode_sel = {1'b1, `FBT_MODE_ARRAY};
      `FBT_CMD_READ_STATUS, `FBT_CMD_CLEAR_STATUS: mode_sel = {1'b1, `FBT_MODE_STATUS};
      `FBT_CMD_READ_SIG: mode_sel = {1'b1, `FBT_MODE_SIG};
      `FBT_CMD_READ_QUERY: mode_sel = {1'b1, `FBT_MODE_QUERY};
      `FBT_CMD_PROGRAM, `FBT_CMD_PROGRAM_ALT, `FBT_CMD_ERASE, `FBT_CMD_BUF_PROG,
      `FBT_CMD_BLANK_SETUP, `FBT_CMD_CONFIRM, `FBT_CMD_SUSPEND,
      `FBT_CMD_BLANK_CONFIRM, `FBT_CMD_LOCK_CONFIRM, `FBT_CMD_LOCKDOWN_CONFIRM,
      `FBT_CMD_SETCFG_CONFIRM: mode_sel = {1'b1, `FBT_MODE_STATUS};
      `FBT_CMD_FACTORY:
      begin
        mode_sel = {1'b1, `FBT_MODE_STATUS};
        is_factory = 1'b1;
      end
      `FBT_CMD_LOCK_SETUP, `FBT_CMD_OTP_SETUP:
      begin
        setup_ignored = pec_busy;
        mode_sel = pec_busy ? 3'h0 : {1'b1, `FBT_MODE_STATUS};
      end
      default: legal = 1'b0;
    endcase
  end
endmodule

// ==== rtl/fbt_bank_tracker.v ====
// Per-bank output mode tracker behind the command interface
`timescale 1ns/1ps
`include "fbt_map.vh"
// Behaviour
// - Selected output type applies only to reads of the bank that got the command.
// - Four modes per bank: array, status, signature, query table data.
// - Bank keeps its last mode until a new command hits that bank.
// - Next interface state computed independently of output mode.
// - Lock/config and OTP setup ignored, both cycles, while controller busy.
// - Factory buffer mode exits on FFFF data to a different block.
// - Undefined codes written in the ready state take the illegal command path; in setup they just return to ready.
module fbt_bank_tracker (
  input wire clk,
  input wire rst_b,
  input wire wr_strobe,
  input wire [`FBT_BANK_W-1:0] wr_bank,
  input wire [`FBT_BLK_W-1:0] wr_block,
  input wire [`FBT_DATA_W-1:0] wr_data,
  input wire pec_busy_pin,
  input wire [`FBT_BANK_W-1:0] rd_bank,
  output reg [`FBT_MODE_W-1:0] rd_mode,
  output wire factory_active,
  output wire illegal_seen,
  output wire setup_pending
);
  localparam ST_READY = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_FACTORY = 2'h2;
  localparam ST_SKIP = 2'h3;

  reg busy_s1_reg;
  reg busy_s2_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`FBT_BLK_W-1:0] first_blk_reg;
  reg [`FBT_BLK_W-1:0] first_blk_next;
  reg illegal_reg;
  reg illegal_next;
  reg factory_setup_reg;
  reg factory_setup_next;
  reg [`FBT_MODE_W-1:0] mode_reg [0:`FBT_NBANK-1];
  wire [2:0] mode_sel;
  wire legal;
  wire setup_ignored;
  wire is_factory;
  wire factory_exit;
  wire cmd_take;
  wire [7:0] cmd_code;
  wire code_is_setup;
  wire code_is_confirm;
  wire same_block;
  wire [`FBT_NBANK-1:0] bank_hit;

  // Busy pin synchroniser
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end
    else
    begin
      busy_s1_reg <= pec_busy_pin;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  fbt_cmd_decode u_dec (
    .code(cmd_code),
    .pec_busy(busy_s2_reg),
    .mode_sel(mode_sel),
    .legal(legal),
    .setup_ignored(setup_ignored),
    .is_factory(is_factory)
  );

  assign factory_exit = (state_reg == ST_FACTORY) && wr_strobe &&
    (wr_block != first_blk_reg) && (wr_data == `FBT_FACTORY_EXIT);
  assign cmd_take = wr_strobe && (state_reg == ST_READY || state_reg == ST_SETUP);
  assign cmd_code = wr_data[7:0];
  assign code_is_setup = (cmd_code == `FBT_CMD_LOCK_SETUP) || (cmd_code == `FBT_CMD_OTP_SETUP);
  assign code_is_confirm = (cmd_code == `FBT_CMD_CONFIRM);
  assign same_block = (wr_block == first_blk_reg);

  // Interface state, no mode input used
  always @*
  begin
    state_next = state_reg;
    first_blk_next = first_blk_reg;
    illegal_next = illegal_reg;
    factory_setup_next = factory_setup_reg;
    if (wr_strobe)
    begin
      case (state_reg)
        ST_READY:
        begin
          if (setup_ignored)
          begin
            state_next = ST_SKIP;
          end
          else if (!legal)
          begin
            illegal_next = 1'b1;
          end
          else if (is_factory || code_is_setup)
          begin
            state_next = ST_SETUP;
            first_blk_next = wr_block;
            factory_setup_next = is_factory;
          end
        end
        ST_SETUP:
        begin
          if (factory_setup_reg && same_block && code_is_confirm)
          begin
            state_next = ST_FACTORY;
          end
          else
          begin
            state_next = ST_READY;
          end
          factory_setup_next = 1'b0;
        end
        ST_FACTORY:
        begin
          if (factory_exit)
          begin
            state_next = ST_READY;
          end
        end
        default:
        begin
          state_next = ST_READY;
        end
      endcase
      if (legal && state_reg == ST_READY && !setup_ignored)
      begin
        illegal_next = 1'b0;
      end
    end
  end

  // Interface state register
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_READY;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // First block of a setup sequence
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_blk_reg <= {`FBT_BLK_W{1'b0}};
    end
    else
    begin
      first_blk_reg <= first_blk_next;
    end
  end

  // Illegal command flag
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      illegal_reg <= 1'b0;
    end
    else
    begin
      illegal_reg <= illegal_next;
    end
  end

  // Setup opened by the factory command
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      factory_setup_reg <= 1'b0;
    end
    else
    begin
      factory_setup_reg <= factory_setup_next;
    end
  end

  // Per-bank output mode store
  genvar gi;
  generate
    for (gi = 0; gi < `FBT_NBANK; gi = gi + 1)
    begin : g_bank
      assign bank_hit[gi] = cmd_take && (wr_bank == gi) && mode_sel[2] && !setup_ignored;

      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          mode_reg[gi] <= `FBT_MODE_RESET;
        end
        else if (bank_hit[gi])
        begin
          mode_reg[gi] <= mode_sel[1:0];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_mode <= `FBT_MODE_RESET;
    end
    else
    begin
      rd_mode <= mode_reg[rd_bank];
    end
  end

  assign factory_active = (state_reg == ST_FACTORY);
  assign illegal_seen = illegal_reg;
  assign setup_pending = (state_reg == ST_SETUP);
endmodule

// ==== tb/fbt_monitor.sv ====
// Checker for the bank output tracker
`timescale 1ns/1ps
module fbt_monitor (
  input wire clk,
  input wire rst_b,
  input wire wr_strobe,
  input wire [3:0] wr_bank,
  input wire [15:0] wr_data,
  input wire pec_busy_pin,
  input wire [3:0] rd_bank,
  input wire [1:0] rd_mode,
  input wire factory_active,
  input wire illegal_seen,
  input wire setup_pending
);
  wire [7:0] c = wr_data[7:0];
  reg bs1_reg;
  reg bs2_reg;
  reg skip_reg;
  wire rdy = !setup_pending && !factory_active && !skip_reg;
  wire st = c == 8'h60 || c == 8'hC0;
  // Second cycle of a setup dropped while busy
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bs1_reg <= 1'b0;
      bs2_reg <= 1'b0;
      skip_reg <= 1'b0;
    end
    else
    begin
      bs1_reg <= pec_busy_pin;
      bs2_reg <= bs1_reg;
      if (wr_strobe)
        skip_reg <= !skip_reg && rdy && st && bs2_reg;
    end
  end
  function [1:0] m(input [7:0] x);
    m = (x == 8'h70) ? 2'h1 : (x == 8'h90) ? 2'h2 : (x == 8'h98) ? 2'h3 : 2'h0;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_array: assert property (!$past(rst_b) |-> rd_mode == 2'h0)
    else $error("reset mode");
  a_mode_hold: assert property (!wr_strobe ##1 !wr_strobe && $stable(rd_bank) |=> $stable(rd_mode))
    else $error("mode drift");
  a_other_bank: assert property (wr_strobe && wr_bank != rd_bank ##1 $stable(rd_bank) |=> $stable(rd_mode))
    else $error("foreign bank");
  a_read_codes: assert property (wr_strobe && wr_bank == rd_bank && rdy && (m(c) != 2'h0 || c == 8'hFF)
    ##1 $stable(rd_bank) |=> rd_mode == m($past(c, 2)))
    else $error("read mode");
  a_busy_ignore: assert property (pec_busy_pin [*4] ##0 wr_strobe && st |=> !setup_pending)
    else $error("busy setup");
  a_skip_ignore: assert property (skip_reg && wr_strobe ##1 $stable(rd_bank) |=> $stable(rd_mode))
    else $error("second cycle used");
  a_setup_taken: assert property (!pec_busy_pin [*4] ##0 wr_strobe && rdy && st |=> setup_pending)
    else $error("setup lost");
  a_illegal_flag: assert property (wr_strobe && rdy && wr_data == 16'h0000 |=> illegal_seen)
    else $error("illegal");
  a_factory_stay: assert property (factory_active && wr_strobe && wr_data != 16'hFFFF |=> factory_active)
    else $error("factory exit");
endmodule
bind fbt_bank_tracker fbt_monitor i_fbt_monitor (.*);

// ==== tb/fbt_host.sv ====
// Host model driving command writes
`timescale 1ns/1ps
module fbt_host (
  input wire clk,
  output reg wr_strobe,
  output reg [3:0] wr_bank,
  output reg [7:0] wr_block,
  output reg [15:0] wr_data
);
  initial {wr_strobe, wr_bank, wr_block, wr_data} = 29'h0;
  task wr(input [3:0] b, input [7:0] k, input [15:0] d);
  begin
    @(negedge clk);
    {wr_strobe, wr_bank, wr_block, wr_data} = {1'b1, b, k, d};
    @(negedge clk);
    wr_strobe = 1'b0;
    wr_data = ~d;
  end
  endtask
endmodule

// ==== tb/tb.sv ====
// Testbench for the bank output tracker
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg bsy = 1'b0;
  reg [3:0] rb = 4'h0;
  wire s, fa, il, sp;
  wire [3:0] b;
  wire [7:0] k;
  wire [15:0] d;
  wire [1:0] md;
  integer err_count = 0;
  integer checks = 0;
  integer i;
  always #20 clk = ~clk;
  fbt_host i_fbt_host (.clk(clk), .wr_strobe(s), .wr_bank(b), .wr_block(k), .wr_data(d));
  fbt_bank_tracker i_fbt_bank_tracker (.clk(clk), .rst_b(rst_b), .wr_strobe(s), .wr_bank(b),
    .wr_block(k), .wr_data(d), .pec_busy_pin(bsy), .rd_bank(rb), .rd_mode(md),
    .factory_active(fa), .illegal_seen(il), .setup_pending(sp));
  task chk(input [1:0] v, input [1:0] e);
  begin
    checks = checks + 1;
    if (v !== e)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h want %h", $time, v, e);
    end
  end
  endtask
  task rd(input [3:0] n, input [1:0] e);
  begin
    @(negedge clk);
    rb = n;
    repeat (2) @(negedge clk);
    chk(md, e);
  end
  endtask
  task w(input [7:0] n, input [15:0] v);
    i_fbt_host.wr(n[3:0], n, v);
  endtask
  task t_modes;
  begin
    for (i = 0; i < 16; i = i + 1)
      rd(i[3:0], 2'h0);
    w(8'h3, 16'h0070);
    rd(4'h3, 2'h1);
    w(8'h5, 16'h0090);
    rd(4'h3, 2'h1);
    rd(4'h5, 2'h2);
    w(8'h3, 16'h0098);
    rd(4'h3, 2'h3);
    w(8'h3, 16'h00FF);
    rd(4'h3, 2'h0);
  end
  endtask
  task t_busy;
  begin
    bsy = 1'b1;
    repeat (4) @(negedge clk);
    w(8'h7, 16'h0060);
    chk({1'b0, sp}, 2'h0);
    w(8'h7, 16'h0090);
    rd(4'h7, 2'h0);
    bsy = 1'b0;
    repeat (4) @(negedge clk);
    w(8'h7, 16'h00C0);
    chk({1'b0, sp}, 2'h1);
    w(8'h7, 16'h0000);
    rd(4'h7, 2'h1);
    w(8'h5, 16'h0000);
    chk({1'b0, il}, 2'h1);
    rd(4'h5, 2'h2);
  end
  endtask
  task t_factory;
  begin
    w(8'h1, 16'h0060);
    w(8'h1, 16'h00D0);
    chk({1'b0, fa}, 2'h0);
    w(8'h1, 16'h0080);
    w(8'h1, 16'h00D0);
    w(8'h1, 16'hFFFF);
    chk({1'b0, fa}, 2'h1);
    i_fbt_host.wr(4'h2, 8'h9, 16'h0090);
    rd(4'h2, 2'h0);
    i_fbt_host.wr(4'h1, 8'h9, 16'hFFFF);
    chk({1'b0, fa}, 2'h0);
  end
  endtask
  task t_reset;
  begin
    w(8'h4, 16'h0000);
    chk({1'b0, il}, 2'h1);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk({1'b0, il}, 2'h0);
    chk({1'b0, fa}, 2'h0);
    rd(4'h5, 2'h0);
    rd(4'h1, 2'h0);
  end
  endtask
  task print_verdict;
  begin
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_modes;
    t_busy;
    t_factory;
    t_reset;
    print_verdict;
  end
endmodule
